// file: src/asc_seq_ctrl.sv
// converter sequence control: registers, sequencer, input selection and buffer addressing
`timescale 1ns/100ps
`include "asc_defs.svh"

module asc_seq_ctrl #(
    parameter int CONV_TAD_10 = `ASC_CONV_TAD_10,
    parameter int CONV_TAD_12 = `ASC_CONV_TAD_12
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_sample_trigger,
    input wire logic i_rc_tick,
    input wire logic [12:0] i_scan_select,
    output asc_pkg::asc_mux_type o_mux,
    output logic [3:0] o_active_channels,
    output logic o_sampling,
    output logic o_converting,
    output logic o_result_strobe,
    output logic [3:0] o_buf_addr,
    output logic [10:0] o_dma_addr,
    output logic o_conv_event
);
    // ************************************************************
    // register file and bus slave
    // ************************************************************
    logic [15:0] seq_q, seq_d, clk_q, clk_d, depth_q, depth_d;
    logic [15:0] aux_q, aux_d, main_q, main_d, ctrl_q, ctrl_d;
    logic done_q, done_d;
    logic wait_q, wait_d;
    logic [31:0] rdata_q, rdata_d;
    logic live_res12;
    logic commit;
    logic [15:0] wdata;
    logic [15:0] rd_val;

    // sequencer state, declared here because status reads it
    asc_pkg::asc_state_type state_q, state_d;
    logic phase_b_q, phase_b_d;
    logic buf_half_q, buf_half_d;
    logic [3:0] int_cnt_q, int_cnt_d;
    logic seq_end;

    assign live_res12 = ctrl_q[`ASC_CTRL_RES];
    // a request is acknowledged one cycle after it rises; the write lands at the edge
    // where the master sees waitrequest low, so the register never changes early
    assign commit = (i_avs_read | i_avs_write) & ~wait_q;
    assign wdata = i_avs_writedata[15:0];

    // read multiplexer; fields unused in twelve-bit mode read as zero
    always_comb begin
        rd_val = 16'h0000;
        unique case (i_avs_address)
            `ASC_OFS_SEQ: begin
                rd_val = seq_q;
                if (live_res12) begin
                    rd_val[`ASC_SEQ_CHCNT +: 2] = 2'h0;
                end
                rd_val[`ASC_SEQ_BUFFER_HALF_STATUS] = buf_half_q;
            end
            `ASC_OFS_CLK: rd_val = clk_q;
            `ASC_OFS_DEPTH: rd_val = depth_q;
            `ASC_OFS_AUX: rd_val = live_res12 ? 16'h0000 : aux_q;
            `ASC_OFS_MAIN: rd_val = main_q;
            `ASC_OFS_CTRL: rd_val = ctrl_q;
            `ASC_OFS_STAT: begin
                rd_val[`ASC_STAT_DONE] = done_q;
                rd_val[`ASC_STAT_BUSY] = (state_q == asc_pkg::ST_SAMPLE) ||
                                         (state_q == asc_pkg::ST_CONVERT);
                rd_val[`ASC_STAT_PHB] = phase_b_q;
                rd_val[`ASC_STAT_HALF] = buf_half_q;
                rd_val[7:4] = int_cnt_q;
            end
            default: rd_val = 16'h0000; // unmapped reads answer zero
        endcase
    end

    // next register values; unmapped writes are dropped
    always_comb begin
        seq_d = seq_q;
        clk_d = clk_q;
        depth_d = depth_q;
        aux_d = aux_q;
        main_d = main_q;
        ctrl_d = ctrl_q;
        done_d = done_q;
        wait_d = wait_q;
        rdata_d = rdata_q;
        if ((i_avs_read | i_avs_write) & wait_q) begin
            wait_d = 1'b0;
            rdata_d = {16'h0000, rd_val};
        end else if (commit) begin
            wait_d = 1'b1;
        end
        if (commit & i_avs_write) begin
            unique case (i_avs_address)
                `ASC_OFS_SEQ: seq_d = wdata & `ASC_MASK_SEQ;
                `ASC_OFS_CLK: clk_d = wdata & `ASC_MASK_CLK;
                `ASC_OFS_DEPTH: depth_d = wdata & `ASC_MASK_DEPTH;
                `ASC_OFS_AUX: aux_d = wdata & `ASC_MASK_AUX;
                `ASC_OFS_MAIN: main_d = wdata & `ASC_MASK_MAIN;
                `ASC_OFS_CTRL: ctrl_d = wdata & `ASC_MASK_CTRL;
                `ASC_OFS_STAT: begin
                    if (wdata[`ASC_STAT_DONE]) begin
                        done_d = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        // completion sets after the clear so that a coinciding end is never lost
        if (seq_end) begin
            done_d = 1'b1;
        end
    end

    // register file flops
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            seq_q <= `ASC_RST_REG;
            clk_q <= `ASC_RST_REG;
            depth_q <= `ASC_RST_REG;
            aux_q <= `ASC_RST_REG;
            main_q <= `ASC_RST_REG;
            ctrl_q <= `ASC_RST_REG;
            done_q <= 1'b0;
            wait_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else begin
            seq_q <= seq_d;
            clk_q <= clk_d;
            depth_q <= depth_d;
            aux_q <= aux_d;
            main_q <= main_d;
            ctrl_q <= ctrl_d;
            done_q <= done_d;
            wait_q <= wait_d;
            rdata_q <= rdata_d;
        end
    end

    assign o_avs_readdata = rdata_q;
    assign o_avs_waitrequest = wait_q;

    // ************************************************************
    // sequencer
    // ************************************************************
    logic [15:0] cseq_q, cseq_d, cclk_q, cclk_d, caux_q, caux_d, cmain_q, cmain_d;
    logic [15:0] cctrl_q, cctrl_d, cdepth_q, cdepth_d;
    logic [7:0] div_q, div_d, div_eff;
    logic [7:0] tcnt_q, tcnt_d;
    logic [1:0] ch_q, ch_d;
    logic [4:0] scan_q, scan_d, scan_pick;
    logic [3:0] buf_q, buf_d;
    logic [6:0] slot_q, slot_d;
    logic conversion_clock_period;
    logic c_res12, c_auto, use_b, last_ch, ch_done;
    logic [2:0] nch;
    logic [7:0] conv_len;
    logic [3:0] smpi;
    asc_pkg::asc_mux_type mux_q, mux_d;
    logic [3:0] act_q, act_d;
    logic strobe_q, strobe_d, event_q, event_d;
    logic [3:0] baddr_q, baddr_d;
    logic [10:0] dma_q, dma_d;
    logic [4:0] an_idx;
    // phase outputs are registered copies of the next state, so they match the state flop
    logic samp_q, samp_d, conv_q, conv_d;

    // first selected scan input at or after the pointer, cyclically over 13 inputs
    function automatic logic [4:0] scan_from(input logic [4:0] start, input logic [12:0] sel);
        logic [4:0] res;
        logic found;
        int idx;
        res = start;
        found = 1'b0;
        for (int i = 0; i < 13; i++) begin
            idx = (int'(start) + i) % 13;
            if (!found && sel[idx]) begin
                res = 5'(idx);
                found = 1'b1;
            end
        end
        return res;
    endfunction

    assign c_res12 = cctrl_q[`ASC_CTRL_RES];
    assign c_auto = cctrl_q[`ASC_CTRL_SSRC +: 3] == `ASC_SSRC_AUTO;
    assign smpi = cseq_q[`ASC_SEQ_SMPI +: 4];
    // reserved divider codes are held at the largest legal divide
    assign div_eff = (cclk_q[`ASC_CLK_DIV +: 8] > `ASC_DIV_MAX) ? `ASC_DIV_MAX :
                     cclk_q[`ASC_CLK_DIV +: 8];
    // conversion clock enable: RC tick, or one pulse per (divider + 1) system cycles
    assign conversion_clock_period = cclk_q[`ASC_CLK_RC] ? i_rc_tick : (div_q == div_eff);
    assign nch = c_res12 ? 3'h1 : cseq_q[`ASC_SEQ_CHCNT + 1] ? 3'h4 :
                 cseq_q[`ASC_SEQ_CHCNT] ? 3'h2 : 3'h1;
    assign conv_len = c_res12 ? 8'(CONV_TAD_12) : 8'(CONV_TAD_10);
    assign last_ch = ({1'b0, ch_q} == 3'(nch - 3'h1));
    assign ch_done = conversion_clock_period && (tcnt_q == 8'(conv_len - 8'h01));
    assign seq_end = (state_q == asc_pkg::ST_CONVERT) && ch_done && last_ch;
    assign use_b = seq_q[`ASC_SEQ_ALTERNATE_SAMPLE_MODE] & phase_b_q;
    assign scan_pick = scan_from(scan_q, i_scan_select);
    // analog input behind the channel being converted
    assign an_idx = (ch_q == 2'h0) ? mux_q.main_pos :
                    5'({2'h0, ch_q} - 5'h01 + (mux_q.aux_pos_high ? 5'h03 : 5'h00));

    // sequencer next state; live settings are captured only when a sequence starts
    always_comb begin
        state_d = state_q;
        cseq_d = cseq_q;
        cclk_d = cclk_q;
        caux_d = caux_q;
        cmain_d = cmain_q;
        cctrl_d = cctrl_q;
        cdepth_d = cdepth_q;
        div_d = (conversion_clock_period || state_q == asc_pkg::ST_IDLE) ? 8'h00 : 8'(div_q + 8'h01);
        tcnt_d = tcnt_q;
        ch_d = ch_q;
        scan_d = scan_q;
        buf_d = buf_q;
        slot_d = slot_q;
        phase_b_d = phase_b_q;
        buf_half_d = buf_half_q;
        int_cnt_d = int_cnt_q;
        mux_d = mux_q;
        act_d = act_q;
        strobe_d = 1'b0;
        event_d = 1'b0;
        baddr_d = baddr_q;
        dma_d = dma_q;
        unique case (state_q)
            asc_pkg::ST_OFF: begin
                phase_b_d = 1'b0;
                buf_half_d = 1'b0;
                int_cnt_d = 4'h0;
                buf_d = 4'h0;
                scan_d = 5'h00;
                slot_d = 7'h00;
                if (ctrl_q[`ASC_CTRL_EN]) begin
                    state_d = asc_pkg::ST_IDLE;
                end
            end
            asc_pkg::ST_IDLE: begin
                cseq_d = seq_q;
                cclk_d = clk_q;
                caux_d = aux_q;
                cmain_d = main_q;
                cctrl_d = ctrl_q;
                cdepth_d = depth_q;
                tcnt_d = 8'h00;
                ch_d = 2'h0;
                mux_d.ref_pos_ext = (seq_q[15:13] == 3'h1) || (seq_q[15:13] == 3'h3);
                mux_d.ref_neg_ext = (seq_q[15:13] == 3'h2) || (seq_q[15:13] == 3'h3);
                if (!use_b && seq_q[`ASC_SEQ_SCAN]) begin
                    mux_d.main_pos = scan_pick;
                    scan_d = (scan_pick == 5'h0c) ? 5'h00 : 5'(scan_pick + 5'h01);
                end else begin
                    mux_d.main_pos = use_b ? main_q[`ASC_MAIN_SB +: 5] :
                                     main_q[`ASC_MAIN_SA +: 5];
                end
                mux_d.main_neg_an1 = use_b ? main_q[`ASC_MAIN_NB] : main_q[`ASC_MAIN_NA];
                mux_d.aux_pos_high = ~ctrl_q[`ASC_CTRL_RES] &
                                     (use_b ? aux_q[`ASC_AUX_SB] : aux_q[`ASC_AUX_SA]);
                mux_d.aux_neg = use_b ? aux_q[`ASC_AUX_NB +: 2] : aux_q[`ASC_AUX_NA +: 2];
                if (!mux_d.aux_neg[1] || ctrl_q[`ASC_CTRL_RES]) begin
                    mux_d.aux_neg = 2'h0;
                end
                act_d = ctrl_q[`ASC_CTRL_RES] ? 4'h1 : seq_q[`ASC_SEQ_CHCNT + 1] ? 4'hf :
                        seq_q[`ASC_SEQ_CHCNT] ? 4'h3 : 4'h1;
                state_d = asc_pkg::ST_SAMPLE;
            end
            asc_pkg::ST_SAMPLE: begin
                if (c_auto) begin
                    // sampling ends once the programmed count of conversion clocks passed
                    if (tcnt_q >= {3'h0, cclk_q[`ASC_CLK_SAMC +: 5]}) begin
                        state_d = asc_pkg::ST_CONVERT;
                        tcnt_d = 8'h00;
                    end else if (conversion_clock_period) begin
                        tcnt_d = 8'(tcnt_q + 8'h01);
                    end
                end else if (i_sample_trigger) begin
                    state_d = asc_pkg::ST_CONVERT;
                    tcnt_d = 8'h00;
                end
            end
            asc_pkg::ST_CONVERT: begin
                if (conversion_clock_period) begin
                    tcnt_d = ch_done ? 8'h00 : 8'(tcnt_q + 8'h01);
                end
                if (ch_done) begin
                    // one result word per channel, in conversion order
                    strobe_d = 1'b1;
                    baddr_d = buf_q;
                    buf_d = 4'(buf_q + 4'h1);
                    if (cctrl_q[`ASC_CTRL_BUILD]) begin
                        dma_d = {7'h00, buf_q};
                    end else begin
                        dma_d = 11'(({6'h00, an_idx} << cdepth_q[2:0]) |
                                ({4'h0, slot_q} & 11'(7'h7f >> (3'h7 - cdepth_q[2:0]))));
                    end
                    ch_d = 2'(ch_q + 2'h1);
                end
                if (seq_end) begin
                    state_d = asc_pkg::ST_IDLE;
                    phase_b_d = cseq_q[`ASC_SEQ_ALTERNATE_SAMPLE_MODE] & ~phase_b_q;
                    if (int_cnt_q == smpi) begin
                        event_d = 1'b1;
                        int_cnt_d = 4'h0;
                        slot_d = 7'(slot_q + 7'h01);
                        buf_half_d = cseq_q[`ASC_SEQ_SPLIT_BUFFER_MODE] & ~buf_half_q;
                        buf_d = (cseq_q[`ASC_SEQ_SPLIT_BUFFER_MODE] & ~buf_half_q) ? 4'h8 : 4'h0;
                    end else begin
                        int_cnt_d = 4'(int_cnt_q + 4'h1);
                    end
                end
            end
        endcase
        if (!ctrl_q[`ASC_CTRL_EN]) begin
            state_d = asc_pkg::ST_OFF;
        end
        samp_d = (state_d == asc_pkg::ST_SAMPLE);
        conv_d = (state_d == asc_pkg::ST_CONVERT);
    end

    // sequencer flops
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            state_q <= asc_pkg::ST_OFF;
            cseq_q <= `ASC_RST_REG;
            cclk_q <= `ASC_RST_REG;
            caux_q <= `ASC_RST_REG;
            cmain_q <= `ASC_RST_REG;
            cctrl_q <= `ASC_RST_REG;
            cdepth_q <= `ASC_RST_REG;
            div_q <= 8'h00;
            tcnt_q <= 8'h00;
            ch_q <= 2'h0;
            scan_q <= 5'h00;
            buf_q <= 4'h0;
            slot_q <= 7'h00;
            phase_b_q <= 1'b0;
            buf_half_q <= 1'b0;
            int_cnt_q <= 4'h0;
            mux_q <= '0;
            act_q <= 4'h0;
            strobe_q <= 1'b0;
            event_q <= 1'b0;
            baddr_q <= 4'h0;
            dma_q <= 11'h000;
            samp_q <= 1'b0;
            conv_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cseq_q <= cseq_d;
            cclk_q <= cclk_d;
            caux_q <= caux_d;
            cmain_q <= cmain_d;
            cctrl_q <= cctrl_d;
            cdepth_q <= cdepth_d;
            div_q <= div_d;
            tcnt_q <= tcnt_d;
            ch_q <= ch_d;
            scan_q <= scan_d;
            buf_q <= buf_d;
            slot_q <= slot_d;
            phase_b_q <= phase_b_d;
            buf_half_q <= buf_half_d;
            int_cnt_q <= int_cnt_d;
            mux_q <= mux_d;
            act_q <= act_d;
            strobe_q <= strobe_d;
            event_q <= event_d;
            baddr_q <= baddr_d;
            dma_q <= dma_d;
            samp_q <= samp_d;
            conv_q <= conv_d;
        end
    end

    // outputs straight from flops
    assign o_mux = mux_q;
    assign o_active_channels = act_q;
    assign o_sampling = samp_q;
    assign o_converting = conv_q;
    assign o_result_strobe = strobe_q;
    assign o_buf_addr = baddr_q;
    assign o_dma_addr = dma_q;
    assign o_conv_event = event_q;

    // ************************************************************
    // checks
    // ************************************************************
    chk_ref_both: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (o_sampling && cseq_q[15:13] == 3'h3) |-> (o_mux.ref_pos_ext && o_mux.ref_neg_ext))
        else $error("both external references not selected");
    chk_chan_twelve: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (o_sampling && c_res12) |-> (o_active_channels == 4'h1))
        else $error("twelve-bit mode must use one channel");
    chk_event_interval: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        $rose(event_q) |-> ($past(int_cnt_q) == $past(smpi) && int_cnt_q == 4'h0))
        else $error("event raised at wrong interval count");
    chk_half_toggle: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (event_d && cseq_q[`ASC_SEQ_SPLIT_BUFFER_MODE] && ctrl_q[`ASC_CTRL_EN])
        |=> (buf_half_q != $past(buf_half_q)) && (buf_q == (buf_half_q ? 4'h8 : 4'h0)))
        else $error("split buffer half did not alternate");
    chk_alt_phase: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (seq_end && !cseq_q[`ASC_SEQ_ALTERNATE_SAMPLE_MODE]) |=> !phase_b_q)
        else $error("phase B used without alternate mode");
    chk_sample_time: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (o_sampling && c_auto && state_d == asc_pkg::ST_CONVERT && ctrl_q[`ASC_CTRL_EN])
        |-> (tcnt_q == {3'h0, cclk_q[`ASC_CLK_SAMC +: 5]}))
        else $error("auto sample time mismatch");
    chk_divider_tick: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (o_converting && !cclk_q[`ASC_CLK_RC] && conversion_clock_period) |-> (div_q <= `ASC_DIV_MAX))
        else $error("conversion clock divider out of range");
    chk_depth_bits: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        depth_q[15:3] == 13'h0000)
        else $error("unimplemented depth bits set");
    chk_off_clear: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (state_q == asc_pkg::ST_OFF) |=> (!phase_b_q && !buf_half_q && int_cnt_q == 4'h0))
        else $error("state not cleared while off");
    chk_bus_answer: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        ((i_avs_read || i_avs_write) && o_avs_waitrequest) |=> !o_avs_waitrequest)
        else $error("bus request not answered in one cycle");
endmodule

// file: src/asc_defs.svh
// register offsets, field positions, reset values and timing counts of the sequence control
`ifndef ASC_DEFS_SVH
`define ASC_DEFS_SVH
// ************************************************************
// register byte offsets
// ************************************************************
`define ASC_OFS_SEQ 8'h00
`define ASC_OFS_CLK 8'h04
`define ASC_OFS_DEPTH 8'h08
`define ASC_OFS_AUX 8'h0c
`define ASC_OFS_MAIN 8'h10
`define ASC_OFS_CTRL 8'h14
`define ASC_OFS_STAT 8'h18
// ************************************************************
// writable masks and reset values
// ************************************************************
`define ASC_MASK_SEQ 16'he73f
`define ASC_MASK_CLK 16'h9fff
`define ASC_MASK_DEPTH 16'h0007
`define ASC_MASK_AUX 16'h0707
`define ASC_MASK_MAIN 16'h9f9f
`define ASC_MASK_CTRL 16'h003f
`define ASC_RST_REG 16'h0000
// ************************************************************
// field positions
// ************************************************************
`define ASC_SEQ_VREF 13
`define ASC_SEQ_SCAN 10
`define ASC_SEQ_CHCNT 8
`define ASC_SEQ_BUFFER_HALF_STATUS 7
`define ASC_SEQ_SMPI 2
`define ASC_SEQ_SPLIT_BUFFER_MODE 1
`define ASC_SEQ_ALTERNATE_SAMPLE_MODE 0
`define ASC_CLK_RC 15
`define ASC_CLK_SAMC 8
`define ASC_CLK_DIV 0
`define ASC_AUX_NB 9
`define ASC_AUX_SB 8
`define ASC_AUX_NA 1
`define ASC_AUX_SA 0
`define ASC_MAIN_NB 15
`define ASC_MAIN_SB 8
`define ASC_MAIN_NA 7
`define ASC_MAIN_SA 0
`define ASC_CTRL_EN 0
`define ASC_CTRL_RES 1
`define ASC_CTRL_SSRC 2
`define ASC_CTRL_BUILD 5
`define ASC_STAT_DONE 0
`define ASC_STAT_BUSY 1
`define ASC_STAT_PHB 2
`define ASC_STAT_HALF 3
// ************************************************************
// codes and timing counts
// ************************************************************
`define ASC_SSRC_AUTO 3'h7
`define ASC_DIV_MAX 8'h3f
`define ASC_CONV_TAD_10 12
`define ASC_CONV_TAD_12 14
`endif

// file: src/asc_pkg.sv
// types shared by the converter sequence control
package asc_pkg;
    // sequencer states
    typedef enum logic [1:0] {
        ST_OFF,
        ST_IDLE,
        ST_SAMPLE,
        ST_CONVERT
    } asc_state_type;

    // input multiplexer and reference selection driven to the analog front end
    typedef struct packed {
        logic ref_pos_ext;
        logic ref_neg_ext;
        logic [4:0] main_pos;
        logic main_neg_an1;
        logic aux_pos_high;
        logic [1:0] aux_neg;
    } asc_mux_type;
endpackage

// file: verif/asc_far_model.sv
// far-side model: converter clock ticks and conversion trigger pulses
`timescale 1ns/100ps
module asc_far_model (
    input wire logic i_clock,
    input wire logic i_rst_n,
    output logic o_rc_tick,
    output logic o_trigger
);
    logic [3:0] cnt_q = 4'h0;
    initial o_rc_tick = 1'b0;
    initial o_trigger = 1'b0;
    // rc tick at counts 0, 3, 6, 9, 12 and 15 of a 16-cycle wrap so rc-clocked runs differ from divider runs
    always @(posedge i_clock) begin
        cnt_q <= i_rst_n ? cnt_q + 4'h1 : 4'h0;
        o_rc_tick <= i_rst_n && (cnt_q % 3 == 0);
        o_trigger <= i_rst_n && (cnt_q[2:0] == 3'h7);
    end
endmodule

// file: verif/asc_seq_ctrl_tb.sv
// self-checking bench of the converter sequence control
`timescale 1ns/100ps
module asc_seq_ctrl_tb;
    logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, run = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0, q, r, rdat;
    logic [31:0] rs = 32'h03bbde27;
    logic [12:0] scan = 13'h0;
    logic wq, stb, ev, tick, trig, smp, cnv;
    logic [3:0] act, ba, smpi;
    logic [4:0] pa, pb;
    logic [10:0] da, mxa, mxb, sel;
    asc_pkg::asc_mux_type mx;
    int error_cnt = 0, checks_done = 0, cyc = 0;
    int nch, k, ptr, half, phb, seqs, evs, split, alternate_sample_mode, res, bld, smps;
    logic [7:0] ofs [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h1c};
    logic [31:0] msk [6] = '{32'he73f, 32'h9fff, 32'h0007, 32'h0707, 32'h9f9f, 32'h0};

    asc_seq_ctrl dut_u (.i_clock(clk), .i_rst_n(rst_n), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdat), .o_avs_waitrequest(wq),
        .i_sample_trigger(trig), .i_rc_tick(tick), .i_scan_select(scan), .o_mux(mx),
        .o_active_channels(act), .o_sampling(smp), .o_converting(cnv), .o_result_strobe(stb),
        .o_buf_addr(ba), .o_dma_addr(da), .o_conv_event(ev));
    asc_far_model far_u (.i_clock(clk), .i_rst_n(rst_n), .o_rc_tick(tick), .o_trigger(trig));

    // 20 MHz clock
    initial begin
        forever #25 clk = ~clk;
    end

    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction

    // inputs 6 to 8 are never chosen, they are reserved on small parts
    function automatic logic [4:0] pick(input logic [3:0] n);
        int p;
        p = n % 10;
        return 5'(p > 5 ? p + 3 : p);
    endfunction

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one bus cycle; request held until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= {16'h0000, d};
        // only the cycle ceiling ends a wait that never comes
        do begin
            @(posedge clk);
        end while (wq !== 1'b0);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // reference model: buffer pointer, sample phase and interval count per result
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            error_cnt++;
            test_done();
        end
        if (run && smp === 1'b1) begin
            smps++;
        end
        if (run && stb === 1'b1) begin
            sel = phb ? mxb : mxa;
            chk("active", {28'h0, act}, (1 << nch) - 1);
            chk("phase", {30'h0, smp, cnv}, k + 1 < nch);
            chk("bufaddr", {28'h0, ba}, ptr);
            // scatter slot is the event count; depth stays 7 from the map test
            chk("dmaaddr", {21'h0, da},
                bld ? ptr : ((k == 0 ? sel[8:4] : k - 1 + 3 * sel[2]) << 7) | evs);
            chk("mux", {21'h0, mx}, {21'h0, sel});
            ptr++;
            k++;
            if (k == nch) begin
                k = 0;
                phb ^= alternate_sample_mode;
                seqs++;
            end
        end
        if (run && ev === 1'b1) begin
            chk("interval", seqs, smpi + 1);
            seqs = 0;
            evs++;
            half ^= split;
            ptr = 8 * half;
        end
    end

    // main sequence: register map, then random conversion set-ups
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, ofs[i], 16'hffff);
            bus(1'b0, ofs[i], 16'h0000);
            chk("regmask", q, msk[i]);
        end
        bus(1'b1, 8'h14, 16'h0002);
        bus(1'b0, 8'h00, 16'h0000);
        chk("seq12", q, 32'he43f);
        bus(1'b0, 8'h0c, 16'h0000);
        chk("aux12", q, 32'h0);
        for (int t = 0; t < 6; t++) begin
            r = rnd();
            res = r[13];
            bld = r[12];
            nch = res ? 1 : r[1] ? 4 : r[0] ? 2 : 1;
            split = r[3];
            alternate_sample_mode = r[2];
            smpi = 4'(r[11:8] % ((split ? 8 : 16) / nch));
            pa = pick(r[15:12]);
            pb = pick(r[19:16]);
            // scan mask holds one allowed input, so the scanned pick is known
            mxa = {!r[6] & r[4], !r[6] & r[5], r[23] ? pick(r[11:8]) : pa, r[21],
                   !res & r[24], !res & r[26] ? r[26:25] : 2'b00};
            mxb = {!r[6] & r[4], !r[6] & r[5], pb, r[20],
                   !res & r[27], !res & r[29] ? r[29:28] : 2'b00};
            scan <= 13'h0001 << pick(r[11:8]);
            bus(1'b1, 8'h04, {r[22], 2'b00, r[30:26], 7'h00, r[31]});
            bus(1'b1, 8'h0c, {5'h00, r[29:27], 5'h00, r[26:24]});
            bus(1'b1, 8'h10, {r[20], 2'b00, pb, r[21], 2'b00, pa});
            bus(1'b1, 8'h00, {r[6:4], 2'h0, r[23], r[1:0], 2'h0, smpi, r[3:2]});
            k = 0;
            ptr = 0;
            half = 0;
            phb = 0;
            seqs = 0;
            evs = 0;
            smps = 0;
            run = 1'b1;
            bus(1'b1, 8'h14, {10'h000, r[12], r[7] ? 3'h7 : 3'h0, r[13], 1'b1});
            for (int n = 0; n < 20000 && evs < 2; n++) @(posedge clk);
            chk("events", evs, 2);
            chk("sampling", smps > 0, 1);
            if (split) begin
                bus(1'b0, 8'h00, 16'h0000);
                chk("half", {31'h0, q[7]}, half);
            end
            bus(1'b1, 8'h14, 16'h0000);
            run = 1'b0;
            // the off state clears its counters one cycle after it is entered
            @(posedge clk);
            bus(1'b0, 8'h18, 16'h0000);
            chk("offstate", q & 32'hfe, 32'h0);
        end
        test_done();
    end
endmodule
